// ===== fcz_top.sv
// Flash current zone scaler top: zone decision, flash gating and thermal shutdown
`timescale 1ns/1ps
`default_nettype none
module fcz_top
    import fcz_pkg::*;
(
    input  wire logic                   I_CLK,
    input  wire logic                   I_RST,
    input  wire logic [FCZ_ADC_W-1:0]   I_LIGHT_TEMP_SENSE_INPUT_MV,
    input  wire logic                   I_SENSE_EN,
    input  wire logic [FCZ_CODE_W-1:0]  I_SENSE_HI_CODE,
    input  wire logic [FCZ_CODE_W-1:0]  I_SENSE_LO_CODE,
    input  wire logic [FCZ_LEVEL_W-1:0] I_PEAK_LEVEL,
    input  wire logic                   I_FLASH_REQ,
    input  wire logic                   I_TEMP_ABOVE_HI,
    input  wire logic                   I_TEMP_BELOW_LO,
    output logic [FCZ_LEVEL_W-1:0]      O_FLASH_LEVEL,
    output logic                        O_FLASH_ON,
    output logic [1:0]                  O_ZONE,
    output logic                        O_SHUTDOWN
);
    // Two-stage synchronisers for the analog-side inputs
    logic [FCZ_ADC_W-1:0]   sense_s1_r;
    logic [FCZ_ADC_W-1:0]   sense_s2_r;
    logic [2:0]             pin_s1_r;
    logic [2:0]             pin_s2_r;
    // Settings and decoded comparisons
    fcz_cfg_type            cfg;
    logic                   above_hi;
    logic                   above_lo;
    logic                   flash_req;
    logic                   t_hi;
    logic                   t_lo;
    // Registered state and its next values
    fcz_zone_type           zone_nxt;
    fcz_zone_type           zone_r;
    logic                   shut_nxt;
    logic                   shut_r;
    logic                   on_nxt;
    logic                   on_r;
    logic [FCZ_LEVEL_W-1:0] lvl_nxt;
    logic [FCZ_LEVEL_W-1:0] lvl_r;
    logic [FCZ_LEVEL_W+6:0] scaled;

    // Sense word is synced as a bus; it must hold a few cycles per change,
    // since a sample taken mid-change can show one torn value for a cycle
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            sense_s1_r <= '0;
            sense_s2_r <= '0;
            pin_s1_r   <= '0;
            pin_s2_r   <= '0;
        end
        else
        begin
            sense_s1_r <= I_LIGHT_TEMP_SENSE_INPUT_MV;
            sense_s2_r <= sense_s1_r;
            pin_s1_r   <= {I_FLASH_REQ, I_TEMP_ABOVE_HI, I_TEMP_BELOW_LO};
            pin_s2_r   <= pin_s1_r;
        end
    end

    // Codes are quasi-static software settings, used directly
    assign cfg       = '{hi_code: I_SENSE_HI_CODE, lo_code: I_SENSE_LO_CODE,
                         sense_en: I_SENSE_EN};
    assign flash_req = pin_s2_r[2];
    assign t_hi      = pin_s2_r[1];
    assign t_lo      = pin_s2_r[0];

    fcz_thresh u_hi (
        .i_code     (cfg.hi_code),
        .i_sense_mv (sense_s2_r),
        .o_above    (above_hi)
    );
    fcz_thresh u_lo (
        .i_code     (cfg.lo_code),
        .i_sense_mv (sense_s2_r),
        .o_above    (above_lo)
    );

    // 70 percent of peak, rounded down; no divider beyond a constant
    assign scaled = (FCZ_LEVEL_W+7)'(I_PEAK_LEVEL) * (FCZ_LEVEL_W+7)'(FCZ_REDUCED_PCT);

    // Zone, shutdown and flash level next-state
    always_comb
    begin
        shut_nxt = shut_r;
        if (t_hi)
            shut_nxt = 1'b1;
        else if (shut_r && t_lo)
            shut_nxt = 1'b0;
        if (!cfg.sense_en)
            zone_nxt = FCZ_ZONE_FULL;
        else if (above_hi)
            zone_nxt = FCZ_ZONE_BLOCKED;
        else if (above_lo)
            zone_nxt = FCZ_ZONE_REDUCED;
        else
            zone_nxt = FCZ_ZONE_FULL;
        // High zone only blocks a start; an ongoing flash continues
        if (shut_nxt || !flash_req)
            on_nxt = 1'b0;
        else if (!on_r)
            on_nxt = (zone_nxt != FCZ_ZONE_BLOCKED);
        else
            on_nxt = 1'b1;
        // Level follows the zone every cycle, even mid-flash
        unique case (zone_nxt)
            FCZ_ZONE_REDUCED: lvl_nxt = FCZ_LEVEL_W'(scaled / FCZ_PCT_FULL);
            FCZ_ZONE_BLOCKED: lvl_nxt = FCZ_LEVEL_W'(scaled / FCZ_PCT_FULL);
            FCZ_ZONE_FULL:    lvl_nxt = I_PEAK_LEVEL;
        endcase
        if (!on_nxt)
            lvl_nxt = FCZ_RST_LEVEL;
    end

    // State registers; reset gives zone full, no flash, no shutdown
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            zone_r <= FCZ_ZONE_FULL;
            shut_r <= 1'b0;
            on_r   <= 1'b0;
            lvl_r  <= FCZ_RST_LEVEL;
        end
        else
        begin
            zone_r <= zone_nxt;
            shut_r <= shut_nxt;
            on_r   <= on_nxt;
            lvl_r  <= lvl_nxt;
        end
    end

    // Outputs come straight from the state registers
    assign O_FLASH_LEVEL = lvl_r;
    assign O_FLASH_ON    = on_r;
    assign O_ZONE        = zone_r;
    assign O_SHUTDOWN    = shut_r;

    // Checks; named steps of a flash start, a thermal trip and a release
    sequence s_start;
        !on_r ##1 on_r;
    endsequence

    sequence s_trip;
        t_hi ##1 shut_r;
    endsequence

    sequence s_release;
        shut_r && t_lo && !t_hi ##1 !shut_r;
    endsequence

    // Start gating by zone, request and shutdown
    a_blocked_no_start: assert property (@(posedge I_CLK) disable iff (I_RST)
        s_start |-> $past(zone_nxt) != FCZ_ZONE_BLOCKED)
        else $error("flash started in blocked zone");

    a_blocked_dark: assert property (@(posedge I_CLK) disable iff (I_RST)
        !on_r && zone_nxt == FCZ_ZONE_BLOCKED |=> !on_r)
        else $error("blocked zone let a flash start");

    a_start_needs_req: assert property (@(posedge I_CLK) disable iff (I_RST)
        s_start |-> $past(flash_req) && !$past(shut_nxt))
        else $error("flash started without request or in shutdown");

    // Level per zone; a peak change takes one cycle to reach the level
    a_full_level: assert property (@(posedge I_CLK) disable iff (I_RST)
        on_r && zone_r == FCZ_ZONE_FULL |-> lvl_r == I_PEAK_LEVEL || $changed(I_PEAK_LEVEL))
        else $error("full zone level wrong");

    a_reduced_level: assert property (@(posedge I_CLK) disable iff (I_RST)
        on_r && zone_r == FCZ_ZONE_REDUCED && $stable(I_PEAK_LEVEL)
        |-> lvl_r == FCZ_LEVEL_W'(scaled / FCZ_PCT_FULL))
        else $error("reduced level wrong");

    a_blocked_level: assert property (@(posedge I_CLK) disable iff (I_RST)
        on_r && zone_r == FCZ_ZONE_BLOCKED && $stable(I_PEAK_LEVEL)
        |-> lvl_r == FCZ_LEVEL_W'(scaled / FCZ_PCT_FULL))
        else $error("running flash in blocked zone at wrong level");

    a_off_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
        !on_r |-> lvl_r == FCZ_RST_LEVEL)
        else $error("level while off");

    a_flash_rides: assert property (@(posedge I_CLK) disable iff (I_RST)
        on_r && flash_req && !t_hi |=> on_r)
        else $error("running flash cut by a zone change");

    // Zone decision from the two comparators
    a_disabled_full: assert property (@(posedge I_CLK) disable iff (I_RST)
        !cfg.sense_en |=> zone_r == FCZ_ZONE_FULL)
        else $error("disabled sense not full");

    a_zone_order: assert property (@(posedge I_CLK) disable iff (I_RST)
        cfg.sense_en && above_hi |=> zone_r == FCZ_ZONE_BLOCKED)
        else $error("zone not blocked");

    a_reduced_zone: assert property (@(posedge I_CLK) disable iff (I_RST)
        cfg.sense_en && !above_hi && above_lo |=> zone_r == FCZ_ZONE_REDUCED)
        else $error("zone not reduced");

    a_full_zone: assert property (@(posedge I_CLK) disable iff (I_RST)
        cfg.sense_en && !above_hi && !above_lo |=> zone_r == FCZ_ZONE_FULL)
        else $error("zone not full");

    // Thermal shutdown with hysteresis
    a_shut_off: assert property (@(posedge I_CLK) disable iff (I_RST)
        t_hi |=> shut_r && !on_r)
        else $error("no shutdown on over-temperature");

    a_shut_dark: assert property (@(posedge I_CLK) disable iff (I_RST)
        shut_r |-> !on_r && lvl_r == FCZ_RST_LEVEL)
        else $error("flash on during shutdown");

    a_trip_holds: assert property (@(posedge I_CLK) disable iff (I_RST)
        s_trip ##0 !t_lo |=> shut_r)
        else $error("trip released above recovery limit");

    a_shut_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
        shut_r && !t_lo && !t_hi |=> shut_r)
        else $error("shutdown released early");

    a_shut_recover: assert property (@(posedge I_CLK) disable iff (I_RST)
        shut_r && t_lo && !t_hi |=> !shut_r)
        else $error("no recovery");

    a_release_restart: assert property (@(posedge I_CLK) disable iff (I_RST)
        s_release ##0 (flash_req && !t_hi) |=> on_r || zone_r == FCZ_ZONE_BLOCKED)
        else $error("no flash after recovery");
endmodule
`default_nettype wire

// ===== fcz_pkg.sv
// Package for the flash current zone scaler: constants and carrier types
// Notes on behaviour
// - The sensed voltage is split into three zones by the high and low thresholds and the flash current follows the zone.
// - Both thresholds can be set anywhere from zero to one volt.
// - One threshold step is about sixteen millivolts of sensed voltage.
// - Above the high threshold a new flash is not allowed to start.
// - Above the low threshold the flash current drops to seventy percent of the programmed peak.
// - Below the low threshold a flash runs at full programmed current.
// - A threshold crossing during a flash changes the current at once to the new zone's level.
// - An over-temperature indication above the upper limit shuts the block down.
// - After shutdown, operation resumes only when the lower recovery limit is passed, giving hysteresis.
// - Each threshold equals one volt times the six-bit code over sixty-three.
package fcz_pkg;

    localparam int          FCZ_CODE_W      = 6;
    localparam int          FCZ_ADC_W       = 12;
    localparam int          FCZ_LEVEL_W     = 8;
    // Full scale in millivolts; code max is 2^6 - 1
    localparam int          FCZ_FULL_MV     = 1000;
    localparam int          FCZ_CODE_MAX    = (1 << FCZ_CODE_W) - 1;
    localparam int          FCZ_STEP_MV     = 16;
    // Reduced current in percent of peak
    localparam int          FCZ_REDUCED_PCT = 70;
    localparam int          FCZ_PCT_FULL    = 100;
    // Thermal limits in degrees C
    localparam int          FCZ_TSD_HI_C    = 145;
    localparam int          FCZ_TSD_LO_C    = 125;
    // Reset values
    localparam logic [5:0]  FCZ_RST_CODE    = 6'h00;
    localparam logic [7:0]  FCZ_RST_LEVEL   = 8'h00;

    typedef enum logic [1:0] {
        FCZ_ZONE_FULL,
        FCZ_ZONE_REDUCED,
        FCZ_ZONE_BLOCKED
    } fcz_zone_type;

    typedef struct packed {
        logic [FCZ_CODE_W-1:0] hi_code;
        logic [FCZ_CODE_W-1:0] lo_code;
        logic                  sense_en;
    } fcz_cfg_type;

endpackage

// ===== fcz_thresh.sv
// Threshold code to millivolt converter and comparator
`timescale 1ns/1ps
`default_nettype none
module fcz_thresh
    import fcz_pkg::*;
(
    input  wire logic [FCZ_CODE_W-1:0] i_code,
    input  wire logic [FCZ_ADC_W-1:0]  i_sense_mv,
    output logic                       o_above
);
    logic [FCZ_ADC_W+FCZ_CODE_W-1:0] lhs;
    logic [FCZ_ADC_W+FCZ_CODE_W-1:0] rhs;

    // Compare sense*63 against code*1000 to avoid a divider
    always_comb
    begin
        lhs     = (FCZ_ADC_W+FCZ_CODE_W)'(i_sense_mv) * (FCZ_ADC_W+FCZ_CODE_W)'(FCZ_CODE_MAX);
        rhs     = (FCZ_ADC_W+FCZ_CODE_W)'(i_code) * (FCZ_ADC_W+FCZ_CODE_W)'(FCZ_FULL_MV);
        o_above = lhs > rhs;
    end
endmodule
`default_nettype wire

// ===== fcz_sense_model.sv
// Sensor divider model driving the digitised sense voltage
`timescale 1ns/1ps
`default_nettype none
module fcz_sense_model
    import fcz_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic [FCZ_ADC_W-1:0] i_target_mv,
    output logic      [FCZ_ADC_W-1:0] o_sense_mv
);
    // Divider settles one cycle after the target moves, never glitching through X
    always_ff @(posedge i_clk)
    begin
        o_sense_mv <= i_target_mv;
    end
endmodule
`default_nettype wire

// ===== tb_flash_current_zone_scaler.sv
// Self-checking bench for the flash current zone scaler
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin $display("wrong value %s exp %0h got %0h", nm, ex, got); fails++; end end
module tb_flash_current_zone_scaler import fcz_pkg::*;;
    typedef struct packed {
        logic [11:0] mv;
        logic        en;
        logic        req;
        logic [7:0]  lvl;
        logic        on;
        logic [1:0]  zone;
    } fcz_row_type;
    logic        clk = 1'b0, rst = 1'b1, sense_en = 1'b1, req = 1'b0, t_hi = 1'b0, t_lo = 1'b1;
    logic [11:0] tgt_mv = 12'h012C, sense_mv;
    logic [5:0]  hi_code = 6'h32, lo_code = 6'h1E;
    logic [7:0]  peak = 8'hC8;
    logic [7:0]  lvl;
    logic        on, sd;
    logic [1:0]  zone;
    int          fails = 0, check_count = 0;
    // Thresholds: hi 50 is 793.6 mV, lo 30 is 476.2 mV; peak 200, reduced 140
    fcz_row_type rows [8] = '{
        '{12'h012C, 1'b1, 1'b1, 8'hC8, 1'b1, 2'h0}, '{12'h01DC, 1'b1, 1'b1, 8'hC8, 1'b1, 2'h0},
        '{12'h01DD, 1'b1, 1'b1, 8'h8C, 1'b1, 2'h1}, '{12'h0319, 1'b1, 1'b1, 8'h8C, 1'b1, 2'h1},
        '{12'h031A, 1'b1, 1'b1, 8'h00, 1'b0, 2'h2}, '{12'h0384, 1'b0, 1'b1, 8'hC8, 1'b1, 2'h0},
        '{12'h012C, 1'b1, 1'b0, 8'h00, 1'b0, 2'h0}, '{12'h0FFF, 1'b1, 1'b0, 8'h00, 1'b0, 2'h2}};

    fcz_sense_model i_sense (.i_clk(clk), .i_target_mv(tgt_mv), .o_sense_mv(sense_mv));
    fcz_top i_dut (.I_CLK(clk), .I_RST(rst), .I_LIGHT_TEMP_SENSE_INPUT_MV(sense_mv),
        .I_SENSE_EN(sense_en), .I_SENSE_HI_CODE(hi_code), .I_SENSE_LO_CODE(lo_code),
        .I_PEAK_LEVEL(peak), .I_FLASH_REQ(req), .I_TEMP_ABOVE_HI(t_hi),
        .I_TEMP_BELOW_LO(t_lo), .O_FLASH_LEVEL(lvl), .O_FLASH_ON(on), .O_ZONE(zone),
        .O_SHUTDOWN(sd));

    always #10 clk = ~clk;

    // Inputs move 1 ns after the edge so sampling never races
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check_out(input logic [7:0] el, input logic eo, input logic [1:0] ez);
        `CHK("level", el, lvl)
        `CHK("flash_on", eo, on)
        `CHK("zone", ez, zone)
    endtask

    // Request dropped first so every row begins with no flash running
    task automatic run_row(input fcz_row_type r);
        req = 1'b0;
        tgt_mv = r.mv;
        sense_en = r.en;
        step(5);
        req = r.req;
        step(5);
        check_out(r.lvl, r.on, r.zone);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Whole run is under two hundred cycles; this cuts a hang
    initial
    begin
        repeat (3000) @(posedge clk);
        fails++;
        give_verdict();
    end

    initial
    begin
        step(4);
        check_out(8'h00, 1'b0, 2'h0);
        rst = 1'b0;
        $display("test reset done");
        foreach (rows[i])
            run_row(rows[i]);
        $display("test zone table done");
        hi_code = 6'h3F;
        run_row('{12'h03E8, 1'b1, 1'b1, 8'h8C, 1'b1, 2'h1});
        run_row('{12'h03E9, 1'b1, 1'b1, 8'h00, 1'b0, 2'h2});
        hi_code = 6'h32;
        $display("test full scale done");
        lo_code = 6'h1F;
        run_row('{12'h01EC, 1'b1, 1'b1, 8'hC8, 1'b1, 2'h0});
        run_row('{12'h01ED, 1'b1, 1'b1, 8'h8C, 1'b1, 2'h1});
        lo_code = 6'h1E;
        $display("test one step done");
        run_row(rows[0]);
        tgt_mv = 12'h0258;
        step(5);
        check_out(8'h8C, 1'b1, 2'h1);
        tgt_mv = 12'h0384;
        step(5);
        check_out(8'h8C, 1'b1, 2'h2);
        tgt_mv = 12'h012C;
        step(5);
        check_out(8'hC8, 1'b1, 2'h0);
        $display("test crossing in flash done");
        peak = 8'hFF;
        step(5);
        check_out(8'hFF, 1'b1, 2'h0);
        tgt_mv = 12'h0258;
        step(5);
        check_out(8'hB2, 1'b1, 2'h1);
        peak = 8'hC8;
        tgt_mv = 12'h012C;
        step(5);
        check_out(8'hC8, 1'b1, 2'h0);
        $display("test peak scaling done");
        t_hi = 1'b1;
        step(5);
        `CHK("shutdown", 1'b1, sd)
        `CHK("flash_on", 1'b0, on)
        t_hi = 1'b0;
        t_lo = 1'b0;
        step(5);
        `CHK("shutdown", 1'b1, sd)
        t_lo = 1'b1;
        step(5);
        `CHK("shutdown", 1'b0, sd)
        `CHK("flash_on", 1'b1, on)
        $display("test thermal done");
        rst = 1'b1;
        step(2);
        check_out(8'h00, 1'b0, 2'h0);
        `CHK("shutdown", 1'b0, sd)
        rst = 1'b0;
        step(2);
        check_out(8'h00, 1'b0, 2'h0);
        step(1);
        check_out(8'hC8, 1'b1, 2'h0);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
